// ### verilog/ipm_pkg.sv
package ipm_pkg;
   // Register offsets on the device's own register port
   localparam logic [7:0] GYRO_RATE_CONTROL_OFS    = 8'h10;
   localparam logic [7:0] GYRO_POWER_CONTROL_OFS   = 8'h12;
   localparam logic [7:0] ACCEL_RATE_CONTROL_OFS   = 8'h20;
   localparam logic [7:0] MAGNET_FIRST_CONTROL_OFS = 8'h20;
   localparam logic [7:0] MAGNET_MODE_CONTROL_OFS  = 8'h22;
   // Field positions
   localparam int RATE_LSB  = 5;
   localparam int LP_BIT    = 7;
   localparam int TCOMP_BIT = 7;
   localparam int MD_LSB    = 0;
   // Gyroscope rate codes
   localparam logic [2:0] RATE_OFF = 3'h0;
   localparam logic [2:0] RATE_14  = 3'h1;
   localparam logic [2:0] RATE_59  = 3'h2;
   localparam logic [2:0] RATE_119 = 3'h3;
   localparam logic [2:0] RATE_238 = 3'h4;
   localparam logic [2:0] RATE_476 = 3'h5;
   localparam logic [2:0] RATE_952 = 3'h6;
   localparam logic [2:0] RATE_RSV = 3'h7;
   // Magnetometer mode codes, overridable per part
   localparam logic [1:0] MAG_MD_CONT_DEF   = 2'h0;
   localparam logic [1:0] MAG_MD_SINGLE_DEF = 2'h1;
   localparam logic [1:0] MAG_MD_OFF_DEF    = 2'h3;
   // Controller APB register map
   localparam logic [7:0] HC_CMD_OFS    = 8'h00;
   localparam logic [7:0] HC_STATUS_OFS = 8'h04;
   localparam int HC_SEL_LSB  = 8;
   localparam int HC_ADDR_LSB = 16;
   localparam int HC_GO_BIT   = 31;

   typedef enum logic [2:0]
   {
      IPM_GPD = 3'b001,
      IPM_GLP = 3'b010,
      IPM_GNM = 3'b100
   } ipm_gyro_state_t;

   typedef enum logic [2:0]
   {
      IPM_MPD = 3'b001,
      IPM_MCC = 3'b010,
      IPM_MSC = 3'b100
   } ipm_mag_state_t;
endpackage : ipm_pkg

// ### verilog/ipm_if.sv
`timescale 1ns/1ps
interface ipm_if;
   logic       wr_ag;
   logic       wr_m;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport dev
   (
      input  wr_ag, wr_m, addr, wdata,
      output rdata
   );
   modport host
   (
      output wr_ag, wr_m, addr, wdata,
      input  rdata
   );
endinterface : ipm_if

// ### verilog/ipm_device.sv
`timescale 1ns/1ps
module ipm_device
#(
   parameter logic [1:0] MAG_MD_CONT   = ipm_pkg::MAG_MD_CONT_DEF,
   parameter logic [1:0] MAG_MD_SINGLE = ipm_pkg::MAG_MD_SINGLE_DEF,
   parameter logic [1:0] MAG_MD_OFF    = ipm_pkg::MAG_MD_OFF_DEF
)
(
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               clk_en,
   // Register port
   ipm_if.dev                      bus,
   // Sensor samples, signed
   input  wire logic signed [15:0] gyro_raw,
   input  wire logic signed [15:0] mag_raw,
   input  wire logic signed [15:0] mag_tcorr,
   // Status
   output logic                    accel_on,
   output logic                    gyro_on,
   output ipm_pkg::ipm_gyro_state_t gyro_state,
   output ipm_pkg::ipm_mag_state_t  mag_state,
   output logic [2:0]              shared_rate,
   output logic signed [15:0]      gyro_out,
   output logic signed [15:0]      mag_out,
   input  wire logic               mag_conv_done
);
   import ipm_pkg::*;

   // Register file
   logic [7:0]      gyro_rate_q;
   logic [7:0]      gyro_power_q;
   logic [7:0]      accel_rate_q;
   logic [7:0]      mag_first_q;
   logic [7:0]      mag_mode_q;
   logic            gyro_act_q;
   logic            mag_bank_q;
   ipm_gyro_state_t gyro_state_d;
   ipm_mag_state_t  mag_state_d;

   // Rate field sits at one place in every rate register
   function automatic logic [2:0] ipm_rate_field(input logic [7:0] v);
      ipm_rate_field = v[RATE_LSB +: 3];
   endfunction : ipm_rate_field

   wire        wr_grate  = bus.wr_ag && bus.addr == GYRO_RATE_CONTROL_OFS;
   wire        wr_gpow   = bus.wr_ag && bus.addr == GYRO_POWER_CONTROL_OFS;
   wire        wr_arate  = bus.wr_ag && bus.addr == ACCEL_RATE_CONTROL_OFS;
   wire        wr_mfirst = bus.wr_m && bus.addr == MAGNET_FIRST_CONTROL_OFS;
   wire        wr_mmode  = bus.wr_m && bus.addr == MAGNET_MODE_CONTROL_OFS;
   // Reserved code is dropped whole, so the gyro keeps its state
   wire        grate_ok  = ipm_rate_field(bus.wdata) != RATE_RSV;
   wire        mag_end   = mag_conv_done && mag_state == IPM_MSC;
   wire [2:0]  grate     = ipm_rate_field(gyro_rate_q);
   wire [1:0]  md        = mag_mode_q[MD_LSB +: 2];
   wire [2:0]  arate     = ipm_rate_field(accel_rate_q);

   // Rates eligible for low-power
   function automatic logic ipm_low_rate(input logic [2:0] r);
      ipm_low_rate = (r == RATE_14) || (r == RATE_59) || (r == RATE_119);
   endfunction : ipm_low_rate

   // Gyro rate and the accel/gyro pairing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gyro_rate_q <= 8'h00;
         gyro_act_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         if (wr_grate && grate_ok)
         begin
            gyro_rate_q <= bus.wdata;
            gyro_act_q  <= 1'b1;
         end
         else if (wr_arate)
         begin
            gyro_act_q  <= 1'b0;
         end
      end
   end

   // Accel rate and gyro power request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         accel_rate_q <= 8'h00;
         gyro_power_q <= 8'h00;
      end
      else if (clk_en)
      begin
         if (wr_arate)
            accel_rate_q <= bus.wdata;
         if (wr_gpow)
            gyro_power_q <= bus.wdata;
      end
   end

   // Magnetometer bank; a host write beats the end of a single conversion
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mag_first_q <= 8'h00;
         mag_mode_q  <= {6'h00, MAG_MD_OFF};
      end
      else if (clk_en)
      begin
         if (wr_mfirst)
            mag_first_q <= bus.wdata;
         if (wr_mmode)
            mag_mode_q <= bus.wdata;
         else if (mag_end)
            mag_mode_q[MD_LSB +: 2] <= MAG_MD_OFF;
      end
   end

   // Bank of the last write picks which register answers at the shared offset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mag_bank_q <= 1'b0;
      else if (clk_en && (bus.wr_ag || bus.wr_m))
         mag_bank_q <= bus.wr_m;
   end

   // Shared rate after a gyro rate write, even one to off; accel alone after an accel write
   assign gyro_on     = gyro_act_q && grate != RATE_OFF;
   assign shared_rate = gyro_act_q ? grate : arate;
   assign accel_on    = shared_rate != RATE_OFF;

   always_comb
   begin
      if (!gyro_on)
         gyro_state_d = IPM_GPD;
      else if (ipm_low_rate(grate) && gyro_power_q[LP_BIT])
         gyro_state_d = IPM_GLP;
      // Fast rates land here whatever the request bit says
      else
         gyro_state_d = IPM_GNM;
   end

   always_comb
   begin
      // Explicit compare: encoding is a parameter, 0 is not power-down
      if (md == MAG_MD_CONT)
         mag_state_d = IPM_MCC;
      else if (md == MAG_MD_SINGLE)
         mag_state_d = IPM_MSC;
      else
         mag_state_d = IPM_MPD;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gyro_state <= IPM_GPD;
         mag_state  <= IPM_MPD;
         gyro_out   <= 16'sh0000;
         mag_out    <= 16'sh0000;
      end
      else if (clk_en)
      begin
         gyro_state <= gyro_state_d;
         mag_state  <= mag_state_d;
         // Samples pass signed; positive means counterclockwise
         gyro_out   <= gyro_on ? gyro_raw : 16'sh0000;
         case (mag_state)
            IPM_MCC, IPM_MSC:
               mag_out <= mag_first_q[TCOMP_BIT] ? mag_tcorr : mag_raw;
            default:
               mag_out <= mag_out;
         endcase
      end
   end

   // Readback
   always_comb
   begin
      bus.rdata = 8'h00;
      if (bus.addr == GYRO_RATE_CONTROL_OFS)
         bus.rdata = gyro_rate_q;
      else if (bus.addr == GYRO_POWER_CONTROL_OFS)
         bus.rdata = gyro_power_q;
      else if (bus.addr == MAGNET_MODE_CONTROL_OFS)
         bus.rdata = mag_mode_q;
      // Strobe lasts one cycle, so the bank comes from a register
      else if (bus.addr == ACCEL_RATE_CONTROL_OFS)
         bus.rdata = mag_bank_q ? mag_first_q : accel_rate_q;
   end
endmodule : ipm_device

// ### verilog/ipm_host.sv
`timescale 1ns/1ps
// Host end: APB slave that issues single register writes to the device
module ipm_host
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Device side
   ipm_if.host              dev
);
   import ipm_pkg::*;

   logic [7:0] addr_q, data_q, rd_q;
   logic       wr_ag_q, wr_m_q;
   logic       ld_q;

   wire acc    = psel && penable && clk_en;
   wire hit_c  = paddr[7:0] == HC_CMD_OFS;
   wire hit_s  = paddr[7:0] == HC_STATUS_OFS;
   wire go     = acc && pwrite && hit_c && pwdata[HC_GO_BIT];

   // Read data is loaded before the access edge so it stands when taken
   wire rd_ld  = psel && !pwrite && !ld_q;

   // Stalls while frozen, so no transfer completes unseen
   assign pready  = clk_en && (pwrite || ld_q);
   assign pslverr = psel && penable && !(hit_c || hit_s);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_q  <= 8'h00;
         data_q  <= 8'h00;
         rd_q    <= 8'h00;
         wr_ag_q <= 1'b0;
         wr_m_q  <= 1'b0;
         ld_q    <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else if (clk_en)
      begin
         wr_ag_q <= go && !pwdata[HC_SEL_LSB];
         wr_m_q  <= go && pwdata[HC_SEL_LSB];
         rd_q    <= dev.rdata;
         if (go)
         begin
            addr_q <= pwdata[HC_ADDR_LSB +: 8];
            data_q <= pwdata[7:0];
         end
         ld_q    <= psel && !pwrite && !(penable && ld_q);
         if (rd_ld)
            prdata <= hit_s ? {24'h000000, rd_q} :
                      {8'h00, addr_q, 8'h00, data_q};
      end
   end

   assign dev.wr_ag = wr_ag_q;
   assign dev.wr_m  = wr_m_q;
   assign dev.addr  = addr_q;
   assign dev.wdata = data_q;
endmodule : ipm_host

// ### verification/ipm_properties.sv
`timescale 1ns/1ps
module ipm_properties
(
   // Clock and reset
   input wire logic                     pclk,
   input wire logic                     presetn,
   // Device strobes
   input wire logic                     wr_ag,
   input wire logic                     wr_m,
   input wire logic [7:0]               addr,
   input wire logic [7:0]               wdata,
   // Device status
   input wire logic                     accel_on,
   input wire logic                     gyro_on,
   input wire logic [2:0]               shared_rate,
   input wire ipm_pkg::ipm_gyro_state_t gyro_state,
   input wire ipm_pkg::ipm_mag_state_t  mag_state
);
   import ipm_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire gyro_wr = wr_ag && !wr_m && addr == GYRO_RATE_CONTROL_OFS;
   wire fast    = shared_rate inside {RATE_238, RATE_476, RATE_952};
   wire slow    = shared_rate inside {RATE_14, RATE_59, RATE_119};
   sequence gyro_fast_held;
      (gyro_on && fast) [*2];
   endsequence
   sequence mag_cont_write;
      wr_m && addr == MAGNET_MODE_CONTROL_OFS && wdata[1:0] == MAG_MD_CONT_DEF;
   endsequence
   AST_ACCEL_ALONE: assert property (wr_ag && !wr_m && addr == ACCEL_RATE_CONTROL_OFS
      |=> !gyro_on ##1 gyro_state == IPM_GPD) else $error("accel write left gyro on");
   AST_BOTH_SHARED: assert property (gyro_wr && wdata[7:5] != RATE_OFF
      && wdata[7:5] != RATE_RSV |=> gyro_on && accel_on && shared_rate == $past(wdata[7:5]))
      else $error("gyro write did not run both at its rate");
   AST_GYRO_NEEDS_ACCEL: assert property (gyro_on |-> accel_on) else $error("gyro alone");
   AST_FAST_NORMAL: assert property (gyro_fast_held |-> gyro_state == IPM_GNM)
      else $error("fast rate not in normal mode");
   AST_LP_SLOW_ONLY: assert property (gyro_state == IPM_GLP |-> $past(slow) && $past(gyro_on))
      else $error("low power at a fast rate");
   AST_OFF_POWER_DOWN: assert property (!gyro_on [*2] |-> gyro_state == IPM_GPD)
      else $error("gyro off but not powered down");
   AST_MAG_START: assert property (mag_cont_write |-> ##2 mag_state == IPM_MCC)
      else $error("continuous mode not entered");
   AST_MAG_RESET_OFF: assert property ($rose(presetn) |-> mag_state == IPM_MPD)
      else $error("magnetometer not off after reset");
   AST_RSV_KEEPS: assert property (gyro_wr && wdata[7:5] == RATE_RSV
      |=> $stable(shared_rate) && $stable(gyro_on)) else $error("reserved rate changed state");
endmodule : ipm_properties

// ### verification/inertial_power_mode_control_test.sv
`timescale 1ns/1ps
module inertial_power_mode_control_test;
   import ipm_pkg::*;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, probe, err_q;
   logic               conv, accel_on, gyro_on, ce;
   logic [31:0]        paddr, pwdata, prdata, obs;
   logic signed [15:0] g_raw, m_raw, m_tc, g_out, m_out;
   logic [2:0]         rate;
   ipm_gyro_state_t    gs;
   ipm_mag_state_t     ms;
   logic [15:0]        lfsr = 16'h001D;
   logic [34:0]        exp_n;
   logic [34:0]        notes [$];
   int                 fail_count = 0;
   int                 check_count = 0;
   ipm_if bus_if ();
   ipm_device ipm_device_inst (.pclk(pclk), .presetn(presetn), .clk_en(ce), .bus(bus_if),
      .gyro_raw(g_raw), .mag_raw(m_raw), .mag_tcorr(m_tc), .accel_on(accel_on),
      .gyro_on(gyro_on), .gyro_state(gs), .mag_state(ms), .shared_rate(rate),
      .gyro_out(g_out), .mag_out(m_out), .mag_conv_done(conv));
   ipm_host ipm_host_inst (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dev(bus_if));
   ipm_properties ipm_properties_inst (.pclk(pclk), .presetn(presetn), .wr_ag(bus_if.wr_ag),
      .wr_m(bus_if.wr_m), .addr(bus_if.addr), .wdata(bus_if.wdata), .accel_on(accel_on),
      .gyro_on(gyro_on), .shared_rate(rate), .gyro_state(gs), .mag_state(ms));
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nxt
   function automatic logic [31:0] st(input logic [2:0] g, m, input logic a, y,
      input logic [2:0] r);
      return {21'h0, g, m, a, y, r};
   endfunction : st
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   // Results of reads and probes arrive in the order they were noted
   always @(posedge pclk)
   begin
      if (probe || (psel && penable && pready && !pwrite))
      begin
         exp_n = notes.pop_front();
         case (exp_n[34:32])
            3'h0: obs = prdata;
            3'h1: obs = {21'h0, gs, ms, accel_on, gyro_on, rate};
            3'h2: obs = {16'h0, g_out};
            3'h3: obs = {16'h0, m_out};
            default: obs = {31'h0, err_q};
         endcase
         check_count++;
         if (obs !== exp_n[31:0])
         begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, obs, exp_n[31:0]);
         end
      end
   end
   task automatic apb(input logic w, input logic [31:0] a, d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      err_q <= pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic look(input logic [2:0] s, input logic [31:0] v);
      notes.push_back({s, v});
      probe <= 1'b1;
      @(posedge pclk);
      probe <= 1'b0;
      @(posedge pclk);
   endtask : look
   // Fixed wait covers strobe, register and state latency
   task automatic dwr(input logic m, input logic [7:0] a, d);
      apb(1'b1, {24'h0, HC_CMD_OFS}, {1'b1, 7'h0, a, 7'h0, m, d});
      repeat (3) @(posedge pclk);
   endtask : dwr
   initial
   begin
      {psel, penable, pwrite, probe, err_q, conv, presetn} = 7'h0;
      {paddr, pwdata, g_raw, m_raw, m_tc} = 112'h0;
      ce = 1'b1;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      look(3'h1, st(IPM_GPD, IPM_MPD, 1'b0, 1'b0, RATE_OFF));
      $display("test reset done");
      for (int lp = 0; lp < 2; lp++)
      begin
         dwr(1'b0, GYRO_POWER_CONTROL_OFS, {lp[0], 7'h0});
         for (int r = 1; r < 7; r++)
         begin
            lfsr = nxt(lfsr);
            g_raw <= lfsr;
            dwr(1'b0, GYRO_RATE_CONTROL_OFS, {r[2:0], lfsr[4:0]});
            look(3'h1, st((lp == 1 && r < 4) ? IPM_GLP : IPM_GNM, IPM_MPD, 1'b1, 1'b1, r[2:0]));
            look(3'h2, {16'h0, lfsr});
            notes.push_back({3'h0, 24'h0, r[2:0], lfsr[4:0]});
            apb(1'b0, {24'h0, HC_STATUS_OFS}, 32'h0);
         end
      end
      $display("test gyro rates done");
      dwr(1'b0, GYRO_RATE_CONTROL_OFS, {RATE_RSV, 5'h0});
      look(3'h1, st(IPM_GNM, IPM_MPD, 1'b1, 1'b1, RATE_952));
      dwr(1'b0, ACCEL_RATE_CONTROL_OFS, {RATE_59, lfsr[4:0]});
      look(3'h1, st(IPM_GPD, IPM_MPD, 1'b1, 1'b0, RATE_59));
      $display("test accel alone done");
      m_raw <= 16'h8001;
      m_tc <= 16'h7FFE;
      dwr(1'b1, MAGNET_FIRST_CONTROL_OFS, 8'h80);
      notes.push_back({3'h0, 24'h0, 8'h80});
      apb(1'b0, {24'h0, HC_STATUS_OFS}, 32'h0);
      dwr(1'b1, MAGNET_MODE_CONTROL_OFS, {6'h0, MAG_MD_CONT_DEF});
      look(3'h1, st(IPM_GPD, IPM_MCC, 1'b1, 1'b0, RATE_59));
      look(3'h3, 32'h0000_7FFE);
      dwr(1'b1, MAGNET_FIRST_CONTROL_OFS, 8'h00);
      look(3'h3, 32'h0000_8001);
      ce <= 1'b0;
      m_raw <= lfsr;
      repeat (3) @(posedge pclk);
      look(3'h3, 32'h0000_8001);
      ce <= 1'b1;
      repeat (2) @(posedge pclk);
      look(3'h3, {16'h0, lfsr});
      dwr(1'b1, MAGNET_MODE_CONTROL_OFS, {6'h0, MAG_MD_SINGLE_DEF});
      look(3'h1, st(IPM_GPD, IPM_MSC, 1'b1, 1'b0, RATE_59));
      notes.push_back({3'h0, 8'h00, MAGNET_MODE_CONTROL_OFS, 14'h0, MAG_MD_SINGLE_DEF});
      apb(1'b0, {24'h0, HC_CMD_OFS}, 32'h0);
      conv <= 1'b1;
      @(posedge pclk);
      conv <= 1'b0;
      repeat (2) @(posedge pclk);
      look(3'h1, st(IPM_GPD, IPM_MPD, 1'b1, 1'b0, RATE_59));
      $display("test magnetometer done");
      apb(1'b1, 32'h0000_0040, 32'h0);
      look(3'h4, 32'h1);
      $display("test unmapped done");
      tally_and_finish;
   end
   // Bench needs under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge pclk);
      fail_count++;
      tally_and_finish;
   end
endmodule : inertial_power_mode_control_test
